// ==== clocked_serial_pkg.sv ====
/*
 * Shared constants for the clocked serial slave transmitter and its
 * external clock master: register offsets, field positions, reset values,
 * bus responses and word lengths.
 * Assumes an AXI4-Lite host with 32-bit data and one register per word.
 */
`default_nettype none
package clocked_serial_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] TX_STATUS_OFS = 8'h00;
	localparam logic [7:0] RX_STATUS_OFS = 8'h04;
	localparam logic [7:0] TX_HOLD_OFS = 8'h08;
	localparam logic [7:0] IRQ_CTRL_OFS = 8'h0c;
	localparam logic [7:0] PIN_SEL_OFS = 8'h10;
	localparam int TX_CLOCK_SOURCE_MASTER_BIT = 7;
	localparam int TX_NINE_EN_BIT = 6;
	localparam int TX_EN_BIT = 5;
	localparam int TX_MODE_BIT = 4;
	localparam int TX_SHIFT_EMPTY_BIT = 1;
	localparam int TX_NINE_VAL_BIT = 0;
	localparam int RX_PORT_EN_BIT = 7;
	localparam int RX_SINGLE_BIT = 5;
	localparam int RX_CONT_BIT = 4;
	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_TX_BUFFER_IRQ_ENABLE_BIT = 1;
	localparam int IRQ_PERIPH_BIT = 2;
	localparam int IRQ_GLOBAL_BIT = 3;
	localparam int IRQ_SLEEP_BIT = 4;
	localparam int PIN_ANALOG_BIT = 0;
	localparam logic CTRL_RST = 1'b0;
	localparam logic ANALOG_RST = 1'b1;
	localparam logic FLAG_RST = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [3:0] WORD_BITS_EIGHT = 4'h8;
	localparam logic [3:0] WORD_BITS_NINE = 4'h9;
	localparam int LINK_HALF_CYCLES = 4;
endpackage
`default_nettype wire

// ==== serial_link_if.sv ====
/*
 * Two-wire clocked serial link between the slave transmitter and the
 * external master. The master drives the serial clock; the slave drives
 * the data wire, which idles high (pull-up) when the slave releases it.
 */
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
	logic serial_timing_pin;
	logic data_dev_out;
	logic data_dev_oe_n;
	logic data_line;

	// released wire is pulled high
	assign data_line = data_dev_oe_n ? 1'b1 : data_dev_out;

	modport device(input serial_timing_pin, output data_dev_out,
		output data_dev_oe_n);
	modport master(output serial_timing_pin, input data_line);
endinterface
`default_nettype wire

// ==== sync_2ff.sv ====
/*
 * Two-flip-flop level synchroniser, WIDTH bits wide.
 * Assumes each bit is a level, or a toggle, held for at least two
 * destination clock edges.
 */
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	// no reset: reset itself passes through one of these
	always_ff @(posedge clk_in) begin
		stage1_r <= d_in;
		stage2_r <= stage1_r;
	end

	assign q_out = stage2_r;
endmodule // sync_2ff
`default_nettype wire

// ==== clocked_serial_master_end.sv ====
/*
 * External clock master: drives the serial clock from clk_in by a divider
 * and collects one 8- or 9-bit word, least significant bit first, per
 * start request.
 * Assumes the slave changes data just after each rising serial edge.
 */
`timescale 1ns/10ps
`default_nettype none
module clocked_serial_master_end
	import clocked_serial_pkg::*;
#(
	parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	serial_link_if.master lnk,
	input wire logic start_in,
	input wire logic nine_bits_in,
	output logic ready_out,
	output logic [8:0] word_out,
	output logic word_valid_out
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HIGH = 3'b010,
		ST_LOW = 3'b100
	} master_state_e;

	master_state_e state_r;
	logic [7:0] phase_r;
	logic [3:0] bit_idx_r;
	logic [3:0] nbits_r;
	logic [8:0] shift_r;
	logic [8:0] word_asm;
	logic link_clk_r;
	logic data_s;
	logic phase_done;

	sync_2ff #(.WIDTH(1)) u_data_sync (
		.clk_in(clk_in),
		.d_in(lnk.data_line),
		.q_out(data_s)
	);

	assign phase_done = (phase_r == 8'(HALF_CYCLES - 1));
	assign word_asm = shift_r | (9'(data_s) << bit_idx_r);
	assign ready_out = (state_r == ST_IDLE);
	assign lnk.serial_timing_pin = link_clk_r;

	// one full clock per bit; sample at the end of the low phase,
	// which leaves the synchroniser a whole period to settle
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_r <= ST_IDLE;
			phase_r <= 8'h00;
			bit_idx_r <= 4'h0;
			nbits_r <= WORD_BITS_EIGHT;
			shift_r <= 9'h000;
			link_clk_r <= 1'b0;
			word_out <= 9'h000;
			word_valid_out <= 1'b0;
		end else begin
			word_valid_out <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (start_in) begin
						state_r <= ST_HIGH;
						link_clk_r <= 1'b1;
						phase_r <= 8'h00;
						bit_idx_r <= 4'h0;
						shift_r <= 9'h000;
						nbits_r <= nine_bits_in ? WORD_BITS_NINE : WORD_BITS_EIGHT;
					end
				end
				ST_HIGH: begin
					if (phase_done) begin
						state_r <= ST_LOW;
						link_clk_r <= 1'b0;
						phase_r <= 8'h00;
					end else begin
						phase_r <= phase_r + 8'h01;
					end
				end
				ST_LOW: begin
					if (phase_done) begin
						phase_r <= 8'h00;
						shift_r <= word_asm;
						if (bit_idx_r == nbits_r - 4'h1) begin
							state_r <= ST_IDLE;
							word_out <= word_asm;
							word_valid_out <= 1'b1;
						end else begin
							bit_idx_r <= bit_idx_r + 4'h1;
							state_r <= ST_HIGH;
							link_clk_r <= 1'b1;
						end
					end else begin
						phase_r <= phase_r + 8'h01;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					link_clk_r <= 1'b0;
				end
			endcase
		end
	end
endmodule // clocked_serial_master_end
`default_nettype wire

// ==== clocked_serial_slave_tx.sv ====
/*
 * Clocked serial slave transmitter with an AXI4-Lite register file.
 * Registers, holding register and sleep/wake logic run on clk_in; the
 * shifter runs on the serial clock that the external master drives.
 * Assumes the master gives the serial clock at least three rising edges
 * while reset is held, before the first word, so the shifter reset takes hold.
 */
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module clocked_serial_slave_tx
	import clocked_serial_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	serial_link_if.device lnk,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic sleep_out,
	output logic wake_out,
	output logic irq_vector_out
);
	logic aw_got_r, w_got_r, wstrb0_r, wr_fire, wr_byte;
	logic [7:0] awaddr_r, wdata_r, rd_byte;
	logic clock_source_master_r, tx_ninth_bit_enable_r;
	logic transmit_enable_r, clocked_mode_select_r, tx_ninth_bit_value_r;
	logic serial_port_enable_r, single_receive_enable_r;
	logic continuous_receive_enable_r, tx_buffer_irq_enable_r;
	logic peripheral_irq_enable_r, global_irq_enable_r;
	logic analog_pin_select_r, sleep_r, tx_buffer_empty_flag_r;
	logic hold_full_r, req_tgl_r, ack_seen_r;
	logic [8:0] hold_data_r, shifter_lk_r;
	logic ack_s, busy_s, ack_evt, hold_wr, tx_active, wake_evt, rd_hit;
	logic rst_lk, req_lk, drive_lk, nine_lk, ack_tgl_lk_r, data_bit_lk_r;
	logic [3:0] bits_left_lk_r;
	// bus write channel: address and data taken in either order
	assign s_axi_awready_out = !aw_got_r;
	assign s_axi_wready_out = !w_got_r;
	assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid_out;
	assign wr_byte = wr_fire && wstrb0_r;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			{aw_got_r, w_got_r, wstrb0_r, awaddr_r, wdata_r} <= 19'h00000;
		end else begin
			if (s_axi_awvalid_in && !aw_got_r) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr_in;
			end else if (wr_fire) begin
				aw_got_r <= 1'b0;
			end
			if (s_axi_wvalid_in && !w_got_r) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata_in[7:0];
				wstrb0_r <= s_axi_wstrb_in[0];
			end else if (wr_fire) begin
				w_got_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= (awaddr_r == TX_STATUS_OFS ||
				awaddr_r == RX_STATUS_OFS || awaddr_r == TX_HOLD_OFS ||
				awaddr_r == IRQ_CTRL_OFS || awaddr_r == PIN_SEL_OFS) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end
	// configuration bits; the shift-empty bit is read only
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			{clock_source_master_r, tx_ninth_bit_enable_r, transmit_enable_r,
				clocked_mode_select_r, tx_ninth_bit_value_r,
				serial_port_enable_r, single_receive_enable_r,
				continuous_receive_enable_r, tx_buffer_irq_enable_r,
				peripheral_irq_enable_r, global_irq_enable_r} <=
				{11{CTRL_RST}};
			analog_pin_select_r <= ANALOG_RST;
		end else if (wr_byte) begin
			if (awaddr_r == TX_STATUS_OFS) begin
				clock_source_master_r <= wdata_r[TX_CLOCK_SOURCE_MASTER_BIT];
				tx_ninth_bit_enable_r <= wdata_r[TX_NINE_EN_BIT];
				transmit_enable_r <= wdata_r[TX_EN_BIT];
				clocked_mode_select_r <= wdata_r[TX_MODE_BIT];
				tx_ninth_bit_value_r <= wdata_r[TX_NINE_VAL_BIT];
			end
			if (awaddr_r == RX_STATUS_OFS) begin
				serial_port_enable_r <= wdata_r[RX_PORT_EN_BIT];
				single_receive_enable_r <= wdata_r[RX_SINGLE_BIT];
				continuous_receive_enable_r <= wdata_r[RX_CONT_BIT];
			end
			if (awaddr_r == IRQ_CTRL_OFS) begin
				tx_buffer_irq_enable_r <= wdata_r[IRQ_TX_BUFFER_IRQ_ENABLE_BIT];
				peripheral_irq_enable_r <= wdata_r[IRQ_PERIPH_BIT];
				global_irq_enable_r <= wdata_r[IRQ_GLOBAL_BIT];
			end
			if (awaddr_r == PIN_SEL_OFS) begin
				analog_pin_select_r <= wdata_r[PIN_ANALOG_BIT];
			end
		end
	end

	// slave transmit needs clocked mode, external clock, port on and
	// both receive enables clear
	assign tx_active = clocked_mode_select_r && !clock_source_master_r &&
		serial_port_enable_r &&
		!single_receive_enable_r && !continuous_receive_enable_r &&
		transmit_enable_r;

	// holding register handoff to the shifter by toggle handshake;
	// data stays frozen while a toggle is outstanding
	sync_2ff #(.WIDTH(2)) u_back_sync (
		.clk_in(clk_in),
		.d_in({ack_tgl_lk_r, (bits_left_lk_r != 4'h0)}),
		.q_out({ack_s, busy_s})
	);

	assign ack_evt = ack_s ^ ack_seen_r;
	// a word written as the previous one is taken is not lost
	assign hold_wr = wr_byte && (awaddr_r == TX_HOLD_OFS) &&
		(!hold_full_r || ack_evt);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			{hold_data_r, hold_full_r, req_tgl_r, ack_seen_r} <= 12'h000;
		end else begin
			ack_seen_r <= ack_s;
			if (hold_wr) begin
				hold_data_r <= {tx_ninth_bit_value_r, wdata_r};
				hold_full_r <= 1'b1;
			end else if (ack_evt) begin
				hold_full_r <= 1'b0;
			end
			if (hold_full_r && !ack_evt && (req_tgl_r == ack_seen_r) &&
				tx_active) begin
				req_tgl_r <= !req_tgl_r;
			end
		end
	end

	// in sleep the flag only rises on a real handoff, so a waiting
	// second word keeps it clear until the first has gone out
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_buffer_empty_flag_r <= FLAG_RST;
		end else if (ack_evt) begin
			// a handoff wins over a refill in the same cycle
			tx_buffer_empty_flag_r <= 1'b1;
		end else if (hold_wr) begin
			tx_buffer_empty_flag_r <= 1'b0;
		end else if (!sleep_r) begin
			tx_buffer_empty_flag_r <= !hold_full_r;
		end
	end
	assign wake_evt = sleep_r && ack_evt &&
		tx_buffer_irq_enable_r && peripheral_irq_enable_r;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sleep_r <= 1'b0;
			wake_out <= 1'b0;
			irq_vector_out <= 1'b0;
		end else begin
			wake_out <= wake_evt;
			irq_vector_out <= wake_evt && global_irq_enable_r;
			if (wake_evt) begin
				sleep_r <= 1'b0;
			end else if (wr_byte && awaddr_r == IRQ_CTRL_OFS) begin
				sleep_r <= wdata_r[IRQ_SLEEP_BIT];
			end
		end
	end
	assign sleep_out = sleep_r;
	// read channel
	always_comb begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		case (s_axi_araddr_in)
			TX_STATUS_OFS: begin
				rd_byte[TX_CLOCK_SOURCE_MASTER_BIT] = clock_source_master_r;
				rd_byte[TX_NINE_EN_BIT] = tx_ninth_bit_enable_r;
				rd_byte[TX_EN_BIT] = transmit_enable_r;
				rd_byte[TX_MODE_BIT] = clocked_mode_select_r;
				rd_byte[TX_SHIFT_EMPTY_BIT] = !busy_s && !hold_full_r;
				rd_byte[TX_NINE_VAL_BIT] = tx_ninth_bit_value_r;
			end
			RX_STATUS_OFS: begin
				rd_byte[RX_PORT_EN_BIT] = serial_port_enable_r;
				rd_byte[RX_SINGLE_BIT] = single_receive_enable_r;
				rd_byte[RX_CONT_BIT] = continuous_receive_enable_r;
			end
			TX_HOLD_OFS: begin
				rd_byte = hold_data_r[7:0];
			end
			IRQ_CTRL_OFS: begin
				rd_byte[IRQ_FLAG_BIT] = tx_buffer_empty_flag_r;
				rd_byte[IRQ_TX_BUFFER_IRQ_ENABLE_BIT] = tx_buffer_irq_enable_r;
				rd_byte[IRQ_PERIPH_BIT] = peripheral_irq_enable_r;
				rd_byte[IRQ_GLOBAL_BIT] = global_irq_enable_r;
				rd_byte[IRQ_SLEEP_BIT] = sleep_r;
			end
			PIN_SEL_OFS: begin
				rd_byte[PIN_ANALOG_BIT] = analog_pin_select_r;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end
	assign s_axi_arready_out = !s_axi_rvalid_out;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= RESP_OKAY;
		end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= {24'h00_0000, rd_byte};
			s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// link domain, clocked by the master's serial clock
	sync_2ff #(.WIDTH(1)) u_rst_sync (
		.clk_in(lnk.serial_timing_pin),
		.d_in(sys_rst_in),
		.q_out(rst_lk)
	);

	// analog pin selection keeps the data wire released
	sync_2ff #(.WIDTH(3)) u_fwd_sync (
		.clk_in(lnk.serial_timing_pin),
		.d_in({req_tgl_r, tx_active && !analog_pin_select_r,
			tx_ninth_bit_enable_r}),
		.q_out({req_lk, drive_lk, nine_lk})
	);

	// load shows bit 0 at once; one bit per rising edge after that,
	// least significant first; next word loads on the edge after
	always_ff @(posedge lnk.serial_timing_pin) begin
		if (rst_lk) begin
			ack_tgl_lk_r <= 1'b0;
			shifter_lk_r <= 9'h000;
			bits_left_lk_r <= 4'h0;
			data_bit_lk_r <= 1'b1;
		end else if (bits_left_lk_r != 4'h0) begin
			data_bit_lk_r <= shifter_lk_r[0];
			shifter_lk_r <= shifter_lk_r >> 1;
			bits_left_lk_r <= bits_left_lk_r - 4'h1;
		end else if ((req_lk != ack_tgl_lk_r) && drive_lk) begin
			data_bit_lk_r <= hold_data_r[0];
			shifter_lk_r <= hold_data_r >> 1;
			bits_left_lk_r <= (nine_lk ? WORD_BITS_NINE : WORD_BITS_EIGHT) -
				4'h1;
			ack_tgl_lk_r <= !ack_tgl_lk_r;
		end
	end

	assign lnk.data_dev_out = data_bit_lk_r;
	assign lnk.data_dev_oe_n = !drive_lk;
endmodule // clocked_serial_slave_tx
`default_nettype wire

// ==== clocked_serial_checker.sv ====
/*
 * Link checker: watches the serial clock and the data wire between the
 * device end and the master end.
 * Assumes the master runs its default divider of four cycles per half.
 */
`timescale 1ns/10ps
`default_nettype none
module clocked_serial_checker (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic serial_timing_pin,
	input wire logic data_dev_out,
	input wire logic data_dev_oe_n,
	input wire logic data_line
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	pullup_idle_a: assert property (data_dev_oe_n |-> data_line)
		else $error("released wire not high");
	drive_pass_a: assert property (
		!data_dev_oe_n |-> data_line == data_dev_out)
		else $error("driven wire differs from data");
	// the shifter is clocked only by the master's rising edge
	edge_change_a: assert property (
		$changed(data_dev_out) |-> serial_timing_pin)
		else $error("data moved away from a rising serial edge");
	bit_stand_a: assert property (
		$rose(serial_timing_pin) |=> $stable(data_dev_out) [*3])
		else $error("data not held through the high phase");
	low_hold_a: assert property (
		!serial_timing_pin && $stable(serial_timing_pin)
		|-> $stable(data_dev_out))
		else $error("data moved while serial clock low");
	// four cycles high: the divider default is kept on purpose
	high_time_a: assert property (
		$rose(serial_timing_pin) |-> serial_timing_pin [*4]
		##1 !serial_timing_pin)
		else $error("serial clock high phase not four cycles");
	reset_idle_a: assert property (
		$fell(sys_rst_in) |-> !serial_timing_pin && data_line)
		else $error("link not idle when reset ends");
	release_high_a: assert property (
		$rose(data_dev_oe_n) |-> data_line)
		else $error("wire not high on release");

	cover property ($rose(serial_timing_pin));
	cover property ($fell(data_dev_oe_n));
	cover property (!data_dev_oe_n && $changed(data_dev_out));
endmodule // clocked_serial_checker
`default_nettype wire

// ==== testbench.sv ====
/*
 * Bench: device end and master end joined by one link; registers over
 * AXI4-Lite; random words from an lfsr, found again on the wire.
 * Assumes both ends share clk_in and the master's default divider.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import clocked_serial_pkg::*;
	localparam logic [7:0] TX_GO = 8'((1 << TX_EN_BIT) | (1 << TX_MODE_BIT));
	localparam logic [7:0] NINE_EN = 8'(1 << TX_NINE_EN_BIT);
	localparam logic [7:0] RA [5] = '{TX_STATUS_OFS, RX_STATUS_OFS,
		IRQ_CTRL_OFS, PIN_SEL_OFS, 8'h14};
	localparam logic [7:0] RV [5] = '{8'h02, 8'h00, 8'h01, 8'h01, 8'h00};
	localparam logic [7:0] TC [5] = '{TX_GO, TX_GO, TX_GO, TX_GO | 8'h80,
		8'h20};
	localparam logic [7:0] RC [5] = '{8'h00, 8'ha0, 8'h90, 8'h80, 8'h80};
	localparam logic [7:0] IV [3] = '{8'h1e, 8'h16, 8'h12};
	localparam logic [1:0] WV [3] = '{2'b11, 2'b10, 2'b00};
	localparam int LIM = 2000;
	logic clk_in, sys_rst_in, dev_rst, start, nine, drive_seen;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, sleep, wake, vec, wvld;
	logic [7:0] awaddr, araddr, d;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, r;
	logic [8:0] word;
	logic [15:0] lfsr;
	logic bits [$];
	logic [8:0] ew [$];
	int en [$];
	int fail_count, tests_run, vcnt, wake_cnt, vec_cnt, p, wc, vc;

	serial_link_if lnk();
	clocked_serial_slave_tx u_clocked_serial_slave_tx (.clk_in(clk_in),
		.sys_rst_in(dev_rst), .lnk(lnk), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.sleep_out(sleep), .wake_out(wake), .irq_vector_out(vec));
	clocked_serial_master_end u_clocked_serial_master_end (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .lnk(lnk), .start_in(start),
		.nine_bits_in(nine), .ready_out(), .word_out(word),
		.word_valid_out(wvld));
	clocked_serial_checker u_clocked_serial_checker (.clk_in(clk_in),
		.sys_rst_in(dev_rst), .serial_timing_pin(lnk.serial_timing_pin),
		.data_dev_out(lnk.data_dev_out), .data_dev_oe_n(lnk.data_dev_oe_n),
		.data_line(lnk.data_line));

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (wvld === 1'b1) vcnt++;
		if (wake === 1'b1) wake_cnt++;
		if (vec === 1'b1) vec_cnt++;
		if (lnk.data_dev_oe_n === 1'b0) drive_seen = 1'b1;
	end
	// wire value just before each rising edge, as a receiver sees it
	always @(posedge lnk.serial_timing_pin) bits.push_back(lnk.data_line);

	function automatic logic [15:0] lfsr_next(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int find(int from, logic [8:0] w, int nb);
		for (int s = from; s + nb <= bits.size(); s++) begin
			int m;
			m = 0;
			for (int i = 0; i < nb; i++) if (bits[s + i] === w[i]) m++;
			if (m == nb) return s + nb;
		end
		return -1;
	endfunction
	task automatic end_of_test();
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp_val(string what, logic [8:0] e, logic [8:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmp_bit(string what, logic e, logic g);
		cmp_val(what, {8'h0, e}, {8'h0, g});
	endtask
	task automatic give_up(int k);
		if (k >= LIM) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v, output logic [1:0] rs);
		logic a_ok, w_ok;
		int k;
		a_ok = 1'b0;
		w_ok = 1'b0;
		k = 0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			k++;
			if (awready === 1'b1) a_ok = 1'b1;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) w_ok = 1'b1;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (!(a_ok && w_ok) && k < LIM);
		while (bvalid !== 1'b1 && k < LIM) begin
			@(posedge clk_in);
			k++;
		end
		rs = bresp;
		bready <= 1'b0;
		give_up(k);
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] v,
		output logic [1:0] rs);
		int k;
		k = 0;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			k++;
		end while (arready !== 1'b1 && k < LIM);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && k < LIM) begin
			@(posedge clk_in);
			k++;
		end
		v = rdata[7:0];
		rs = rresp;
		rready <= 1'b0;
		give_up(k);
	endtask
	task automatic poll(logic [7:0] a, int b, logic v);
		logic [7:0] x;
		logic [1:0] rs;
		int k;
		k = 0;
		do begin
			rd(a, x, rs);
			k++;
		end while (x[b] !== v && k < LIM);
		give_up(k);
	endtask
	task automatic frames(int f);
		int base, k;
		base = vcnt;
		k = 0;
		while (vcnt < base + f && k < LIM) begin
			@(posedge clk_in);
			k++;
		end
		give_up(k);
	endtask
	task automatic put(logic [7:0] v, logic nb, logic b9);
		logic [1:0] rs;
		wr(TX_HOLD_OFS, v, rs);
		ew.push_back({nb & b9, v});
		en.push_back(nb ? 9 : 8);
	endtask
	task automatic send(logic [7:0] v, logic nb, logic b9);
		logic [1:0] rs;
		poll(IRQ_CTRL_OFS, IRQ_FLAG_BIT, 1'b1);
		if (nb) wr(TX_STATUS_OFS, TX_GO | NINE_EN | {7'h0, b9}, rs);
		put(v, nb, b9);
	endtask

	initial begin
		{sys_rst_in, dev_rst} = 2'b11;
		{start, nine, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		{fail_count, tests_run, vcnt, wake_cnt, vec_cnt} = '0;
		drive_seen = 1'b0;
		lfsr = 16'he13b;
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		start <= 1'b1;
		// link side resets only on serial edges, so clock it under reset,
		// then let the serial clock stop before the device leaves reset
		frames(1);
		start <= 1'b0;
		frames(1);
		dev_rst <= 1'b0;
		start <= 1'b1;
		frames(2);
		start <= 1'b0;
		cmp_val("released word", 9'h0ff, {1'b0, word[7:0]});
		for (int i = 0; i < 5; i++) begin
			rd(RA[i], d, r);
			cmp_val("reset value", {1'b0, RV[i]}, {1'b0, d});
			cmp_val("read resp", {7'h0, i == 4 ? RESP_SLVERR : RESP_OKAY},
				{7'h0, r});
		end
		wr(8'h14, 8'hff, r);
		cmp_val("unmapped write", {7'h0, RESP_SLVERR}, {7'h0, r});
		wr(PIN_SEL_OFS, 8'h00, r);
		put(lfsr[7:0], 1'b0, 1'b0);
		lfsr = lfsr_next(lfsr);
		for (int i = 0; i < 5; i++) begin
			wr(TX_STATUS_OFS, TC[i], r);
			wr(RX_STATUS_OFS, RC[i], r);
			drive_seen = 1'b0;
			start <= 1'b1;
			frames(2);
			start <= 1'b0;
			cmp_bit("wire driven", 1'b0, drive_seen);
			rd(IRQ_CTRL_OFS, d, r);
			cmp_bit("word held back", 1'b0, d[IRQ_FLAG_BIT]);
		end
		wr(RX_STATUS_OFS, 8'(1 << RX_PORT_EN_BIT), r);
		wr(TX_STATUS_OFS, TX_GO, r);
		start <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			poll(TX_STATUS_OFS, TX_SHIFT_EMPTY_BIT, i < 4 || i > 4);
			nine <= i >= 4;
			send(lfsr[7:0], i >= 4, lfsr[9]);
			lfsr = lfsr_next(lfsr);
		end
		cmp_val("stray wake", 9'h000, 9'(wake_cnt + vec_cnt));
		for (int i = 0; i < 3; i++) begin
			poll(TX_STATUS_OFS, TX_SHIFT_EMPTY_BIT, 1'b1);
			wr(TX_STATUS_OFS, TX_GO | NINE_EN | {7'h0, lfsr[8]},
				r);
			put(lfsr[7:0], 1'b1, lfsr[8]);
			poll(TX_STATUS_OFS, TX_SHIFT_EMPTY_BIT, 1'b0);
			// holding is one deep: wait for the shifter to take it
			poll(IRQ_CTRL_OFS, IRQ_FLAG_BIT, 1'b1);
			put(lfsr[15:8], 1'b1, lfsr[8]);
			lfsr = lfsr_next(lfsr);
			rd(IRQ_CTRL_OFS, d, r);
			cmp_bit("flag after refill", 1'b0, d[IRQ_FLAG_BIT]);
			wc = wake_cnt;
			vc = vec_cnt;
			wr(IRQ_CTRL_OFS, IV[i], r);
			rd(IRQ_CTRL_OFS, d, r);
			cmp_bit("flag in sleep", 1'b0, d[IRQ_FLAG_BIT]);
			cmp_bit("asleep", 1'b1, sleep);
			poll(IRQ_CTRL_OFS, IRQ_FLAG_BIT, 1'b1);
			cmp_val("wake pulses", {8'h0, WV[i][1]}, 9'(wake_cnt - wc));
			cmp_val("vector pulses", {8'h0, WV[i][0]}, 9'(vec_cnt - vc));
			cmp_bit("still asleep", !WV[i][1], sleep);
			wr(IRQ_CTRL_OFS, 8'h00, r);
		end
		poll(TX_STATUS_OFS, TX_SHIFT_EMPTY_BIT, 1'b1);
		frames(2);
		start <= 1'b0;
		p = 0;
		foreach (ew[i]) begin
			p = find(p, ew[i], en[i]);
			cmp_bit("word on wire", 1'b1, p >= 0);
			if (p < 0) p = 0;
		end
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
